// ===== fdf_top.v
// Function
// - a starting fan 3 jumps from zero duty straight to the start field times 8, field resets to 5h.
// - a slowing fan 3 drops to zero duty once its demand falls below the start field times 4.
// - a power-on duty byte kept from before shutdown is loaded as the fan duty at power-up, byte resets to 66h.
// - with no kept byte, power-up duty is 100% when the full-duty select is 0 and 40% when it is 1.
// - the full-duty select is captured at power-on from the serial DTR strap pin.
// - the bank-select bit, bit 7 of the fault-time register, hides the banked registers: they read 0 and ignore writes.
// - a fault event is raised when duty is FFh and the count misses the expected count within the fault time.
// - the 4-bit fault-time field N means N+1 seconds and resets to Ah.
// - a fault event is also raised when a fan is stopped while its duty exceeds its minimum duty.
// - reading the fan 1 count high byte latches the low byte; software reads high then low.
// - the full-speed count pair latches the same way and resets to 03h and FFh.
// - in speed mode the expected pair holds the target count, updated by hardware in auto mode.
// - in duty mode the expected high byte is reserved and the low byte holds the duty value.
// - above boundary 1 the expected value comes from segment 1, below boundary minus hysteresis from segment 2.
// - the boundary 1 byte is a signed temperature and resets to 3Ch.
// - the 4-bit hysteresis keeps the segment unchanged between boundary minus hysteresis and boundary.
`timescale 1ns/10ps
`include "fdf_map.vh"
module fdf_top #(
   parameter SEC_CYCLES = `FDF_SEC_CYCLES
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // power-on
   input  wire        serial_dtr_strap_pin,
   input  wire        pon_duty_kept,
   // fan 1 side
   input  wire [15:0] fan1_tach_count,
   input  wire        fan1_stopped,
   input  wire [3:0]  fan1_min_start,
   input  wire [1:0]  first_fan_mode_field,
   input  wire [3:0]  first_fan_hysteresis,
   input  wire [7:0]  temperature_source_one,
   input  wire [7:0]  fan1_segment1,
   input  wire [7:0]  fan1_segment2,
   output reg  [7:0]  fan1_duty,
   // fan 3 side
   input  wire [7:0]  fan3_demand,
   input  wire        fan3_stopped,
   output reg  [7:0]  fan3_duty,
   // system
   output reg         bank_select_bit,
   output reg         irq
);
   // registers
   reg  [3:0] third_start_duty;
   reg  [7:0] power_on_duty_byte;
   reg        full_duty_sel;
   reg  [3:0] fault_time;
   reg  [7:0] cnt_hi;
   reg  [7:0] cnt_lo;
   reg  [7:0] cnt_lo_latch;
   reg  [7:0] exp_hi;
   reg  [7:0] exp_lo;
   reg  [7:0] full_hi;
   reg  [7:0] full_lo;
   reg  [7:0] full_lo_latch;
   reg  [7:0] boundary_one_temp;
   reg  [1:0] status;
   reg  [1:0] mask;
   reg        strap_done;
   reg        seg_one;
   reg  [1:0] next_status;
   reg  [31:0] next_rdata;
   reg        next_err;
   reg  [7:0] next_f3;

   wire       duty_mode = first_fan_mode_field[0];
   wire       auto_mode = ~first_fan_mode_field[1];

   // apb decode
   wire [7:0] idx      = paddr[9:2];
   wire       aligned  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
   wire       setup_ok = psel & penable & ~pready;
   wire       done     = psel & penable & pready;
   wire       wr       = done & pwrite & ~pslverr;
   wire       rd       = done & ~pwrite & ~pslverr;
   wire       own_bank = ~bank_select_bit;
   // low byte is latched on the edge that samples the high byte, so the pair is coherent
   wire       rd_take  = setup_ok & ~pwrite & ~next_err;

   // signed temperature compare with hysteresis
   wire signed [9:0] temp_s  = {{2{temperature_source_one[7]}}, temperature_source_one};
   wire signed [9:0] bound_s = {{2{boundary_one_temp[7]}}, boundary_one_temp};
   wire signed [9:0] low_s   = bound_s - $signed({6'h00, first_fan_hysteresis});
   wire [7:0] seg_val = seg_one ? fan1_segment1 : fan1_segment2;

   // fan 3 thresholds and fan 1 minimum duty
   wire [7:0] f3_start = {1'b0, third_start_duty, 3'b000};
   wire [7:0] f3_stop  = {2'b00, third_start_duty, 2'b00};
   wire [7:0] f1_min   = {2'b00, fan1_min_start, 2'b00};

   // fault conditions
   wire [15:0] exp_cnt = {exp_hi, exp_lo};
   wire [15:0] cnt_val = {cnt_hi, cnt_lo};
   wire f1_slow   = (fan1_duty == `FDF_DUTY_FULL) && (cnt_val > exp_cnt);
   wire f1_expire;
   wire f1_stall  = fan1_stopped && (fan1_duty > f1_min);
   wire f3_stall  = fan3_stopped && (fan3_duty > f3_stop);
   reg  f1_stall_d;
   reg  f3_stall_d;

   fdf_fault_timer #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_f1_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .cond    (f1_slow),
      .secs_m1 (fault_time),
      .expired (f1_expire)
   );

   // read mux and unmapped answer
   always @*
   begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (!aligned)
         next_err = 1'b1;
      else if (idx == `FDF_IX_FAULT)
         next_rdata[7:0] = {bank_select_bit, 2'b00, full_duty_sel, fault_time};
      else if (idx == `FDF_IX_STATUS)
         next_rdata[1:0] = status;
      else if (idx == `FDF_IX_MASK)
         next_rdata[1:0] = mask;
      else if (!own_bank)
         next_rdata = 32'h0000_0000;
      else
      begin
         case (idx)
            `FDF_IX_F3_START: next_rdata[3:0] = third_start_duty;
            `FDF_IX_PON_DUTY: next_rdata[7:0] = power_on_duty_byte;
            `FDF_IX_CNT_HI:   next_rdata[7:0] = cnt_hi;
            `FDF_IX_CNT_LO:   next_rdata[7:0] = cnt_lo_latch;
            `FDF_IX_EXP_HI:   next_rdata[7:0] = duty_mode ? 8'h00 : exp_hi;
            `FDF_IX_EXP_LO:   next_rdata[7:0] = exp_lo;
            `FDF_IX_FULL_HI:  next_rdata[7:0] = full_hi;
            `FDF_IX_FULL_LO:  next_rdata[7:0] = full_lo_latch;
            `FDF_IX_BOUND1:   next_rdata[7:0] = boundary_one_temp;
            default:          next_err = 1'b1;
         endcase
      end
   end

   // one wait state so prdata and pready leave flip-flops
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setup_ok;
         pslverr <= setup_ok & next_err;
         if (setup_ok)
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
   end

   // software registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         third_start_duty   <= `FDF_RST_F3_START;
         power_on_duty_byte <= `FDF_RST_PON_DUTY;
         bank_select_bit    <= 1'b0;
         fault_time         <= `FDF_RST_FTIME;
         full_hi            <= `FDF_RST_FULL_HI;
         full_lo            <= `FDF_RST_FULL_LO;
         boundary_one_temp  <= `FDF_RST_BOUND1;
         mask               <= 2'b00;
      end
      else if (wr)
      begin
         case (idx)
            `FDF_IX_FAULT:
            begin
               bank_select_bit <= pwdata[`FDF_FLD_BANK];
               fault_time      <= pwdata[3:0];
            end
            `FDF_IX_MASK: mask <= pwdata[1:0];
            default:
            begin
               if (own_bank && idx == `FDF_IX_F3_START)
                  third_start_duty <= pwdata[3:0];
               if (own_bank && idx == `FDF_IX_PON_DUTY)
                  power_on_duty_byte <= pwdata[7:0];
               if (own_bank && idx == `FDF_IX_FULL_HI)
                  full_hi <= pwdata[7:0];
               if (own_bank && idx == `FDF_IX_FULL_LO)
                  full_lo <= pwdata[7:0];
               if (own_bank && idx == `FDF_IX_BOUND1)
                  boundary_one_temp <= pwdata[7:0];
            end
         endcase
      end
   end

   // strap capture and power-on duty, one clock after reset release
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_done    <= 1'b0;
         full_duty_sel <= 1'b1;
         fan1_duty     <= `FDF_DUTY_FULL;
      end
      else
      begin
         if (!strap_done)
         begin
            strap_done    <= 1'b1;
            full_duty_sel <= serial_dtr_strap_pin;
            if (pon_duty_kept)
               fan1_duty <= power_on_duty_byte;
            else
               fan1_duty <= serial_dtr_strap_pin ? `FDF_DUTY_40 : `FDF_DUTY_FULL;
         end
         else
         begin
            if (wr && idx == `FDF_IX_FAULT)
               full_duty_sel <= pwdata[`FDF_FLD_FULLSEL];
            // duty mode drives the output from the expected duty byte
            if (duty_mode)
               fan1_duty <= exp_lo;
         end
      end
   end

   // count sampling and high-first latching
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_hi        <= `FDF_RST_CNT_HI;
         cnt_lo        <= `FDF_RST_CNT_LO;
         cnt_lo_latch  <= `FDF_RST_CNT_LO;
         full_lo_latch <= `FDF_RST_FULL_LO;
      end
      else
      begin
         // high byte freezes during a high read so the pair stays coherent
         if (!(rd && own_bank && idx == `FDF_IX_CNT_HI))
         begin
            cnt_hi <= fan1_tach_count[15:8];
            cnt_lo <= fan1_tach_count[7:0];
         end
         if (rd_take && own_bank && idx == `FDF_IX_CNT_HI)
            cnt_lo_latch <= cnt_lo;
         if (rd_take && own_bank && idx == `FDF_IX_FULL_HI)
            full_lo_latch <= full_lo;
      end
   end

   // segment selection with hysteresis band
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         seg_one <= 1'b0;
      else if (temp_s > bound_s)
         seg_one <= 1'b1;
      else if (temp_s < low_s)
         seg_one <= 1'b0;
   end

   // expected pair, hardware owns it in auto mode
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         exp_hi <= `FDF_RST_EXP_HI;
         exp_lo <= `FDF_RST_EXP_LO;
      end
      else if (auto_mode)
      begin
         exp_hi <= 8'h00;
         exp_lo <= seg_val;
      end
      else if (wr && own_bank)
      begin
         if (idx == `FDF_IX_EXP_HI && !duty_mode)
            exp_hi <= pwdata[7:0];
         if (idx == `FDF_IX_EXP_LO)
            exp_lo <= pwdata[7:0];
      end
   end

   // fan 3 duty shaping
   always @*
   begin
      next_f3 = fan3_demand;
      if (fan3_demand < f3_stop)
         next_f3 = 8'h00;
      else if (fan3_duty == 8'h00 && fan3_demand < f3_start)
         next_f3 = f3_start;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fan3_duty <= 8'h00;
      else if (fan3_duty == 8'h00 && fan3_demand != 8'h00)
         fan3_duty <= (fan3_demand < f3_stop) ? 8'h00 : f3_start;
      else
         fan3_duty <= next_f3;
   end

   // sticky status, set beats write-one-to-clear
   always @*
   begin
      next_status = status;
      if (wr && idx == `FDF_IX_STATUS)
         next_status = status & ~pwdata[1:0];
      if (f1_expire || (f1_stall && !f1_stall_d))
         next_status[`FDF_ST_F1_FAULT] = 1'b1;
      if (f3_stall && !f3_stall_d)
         next_status[`FDF_ST_F3_FAULT] = 1'b1;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status     <= 2'b00;
         f1_stall_d <= 1'b0;
         f3_stall_d <= 1'b0;
         irq        <= 1'b0;
      end
      else
      begin
         status     <= next_status;
         f1_stall_d <= f1_stall;
         f3_stall_d <= f3_stall;
         irq        <= |(next_status & mask);
      end
   end
endmodule // fdf_top

// ===== fdf_map.vh
`ifndef FDF_MAP_VH
`define FDF_MAP_VH
// register indices, byte address is four times the index
`define FDF_IX_F3_START   8'h9D
`define FDF_IX_PON_DUTY   8'h9E
`define FDF_IX_FAULT      8'h9F
`define FDF_IX_CNT_HI     8'hA0
`define FDF_IX_CNT_LO     8'hA1
`define FDF_IX_EXP_HI     8'hA2
`define FDF_IX_EXP_LO     8'hA3
`define FDF_IX_FULL_HI    8'hA4
`define FDF_IX_FULL_LO    8'hA5
`define FDF_IX_BOUND1     8'hA6
`define FDF_IX_STATUS     8'hB0
`define FDF_IX_MASK       8'hB1
// reset values
`define FDF_RST_F3_START  4'h5
`define FDF_RST_PON_DUTY  8'h66
`define FDF_RST_FTIME     4'hA
`define FDF_RST_CNT_HI    8'h0F
`define FDF_RST_CNT_LO    8'hFF
`define FDF_RST_EXP_HI    8'h00
`define FDF_RST_EXP_LO    8'h01
`define FDF_RST_FULL_HI   8'h03
`define FDF_RST_FULL_LO   8'hFF
`define FDF_RST_BOUND1    8'h3C
// fault/bank register fields
`define FDF_FLD_BANK      7
`define FDF_FLD_FULLSEL   4
// status bits
`define FDF_ST_F1_FAULT   0
`define FDF_ST_F3_FAULT   1
// duty levels
`define FDF_DUTY_FULL     8'hFF
`define FDF_DUTY_40       8'h66
// timing
`define FDF_CLK_NS        50
`define FDF_ONE_SEC_NS    1000000000
`define FDF_SEC_CYCLES    (`FDF_ONE_SEC_NS / `FDF_CLK_NS)
`endif

// ===== fdf_fault_timer.v
`timescale 1ns/10ps
`include "fdf_map.vh"
module fdf_fault_timer #(
   parameter SEC_CYCLES = `FDF_SEC_CYCLES,
   parameter CW         = 25
) (
   // clock and reset
   input  wire          pclk,
   input  wire          presetn,
   // control
   input  wire          cond,
   input  wire [3:0]    secs_m1,
   // result
   output reg           expired
);
   reg [CW-1:0] cyc;
   reg [4:0]    secs;
   wire         sec_tick = (cyc == SEC_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

   // field N means N+1 whole seconds; restarts whenever the condition drops
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cyc     <= {CW{1'b0}};
         secs    <= 5'h00;
         expired <= 1'b0;
      end
      else
      begin
         expired <= 1'b0;
         if (!cond)
         begin
            cyc  <= {CW{1'b0}};
            secs <= 5'h00;
         end
         else if (sec_tick)
         begin
            cyc <= {CW{1'b0}};
            if (secs == {1'b0, secs_m1})
            begin
               expired <= 1'b1;
               secs    <= 5'h00;
            end
            else
               secs <= secs + 5'h01;
         end
         else
            cyc <= cyc + {{(CW-1){1'b0}}, 1'b1};
      end
   end
endmodule // fdf_fault_timer

// ===== fdf_props.sv
`timescale 1ns/10ps
module fdf_props #(
   parameter SEC_CYCLES = 20
) (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   // power-on and fans
   input wire        serial_dtr_strap_pin,
   input wire        pon_duty_kept,
   input wire [7:0]  fan1_duty,
   input wire [7:0]  fan3_demand,
   input wire [7:0]  fan3_duty,
   input wire        bank_select_bit
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_boot;
      presetn && !$past(presetn);
   endsequence
   sequence s_restart;
      $past(fan3_duty) == 8'h00 && fan3_duty != 8'h00;
   endsequence
   sequence s_stop;
      $past(fan3_duty) != 8'h00 && fan3_duty == 8'h00;
   endsequence
   chk_apb_wait:
      assert property (s_wait |=> pready)
      else $error("access phase not answered after one wait");
   chk_ready_once:
      assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   chk_err_ready:
      assert property (pslverr |-> pready && psel && penable)
      else $error("error flag outside an answer");
   chk_start_jump:
      assert property (s_restart |-> fan3_duty[2:0] == 3'h0 && fan3_duty <= 8'h78)
      else $error("fan 3 restart not at start field times eight");
   // start field is at most 15, so any drop needs a demand under 60
   chk_stop_drop:
      assert property (s_stop |-> $past(fan3_demand) < 8'h3C)
      else $error("fan 3 stopped with demand above the floor");
   chk_boot_kept:
      assert property ((s_boot and pon_duty_kept) |=> fan1_duty == 8'h66)
      else $error("kept power-on byte not loaded");
   chk_boot_full:
      assert property ((s_boot and !pon_duty_kept and !serial_dtr_strap_pin)
         |=> fan1_duty == 8'hFF)
      else $error("full duty not loaded with strap low");
   chk_boot_forty:
      assert property ((s_boot and !pon_duty_kept and serial_dtr_strap_pin)
         |=> fan1_duty == 8'h66)
      else $error("forty percent not loaded with strap high");
   chk_bank_cause:
      assert property ($changed(bank_select_bit) |-> $past(psel && penable && pready && pwrite
         && paddr[9:2] == 8'h9F) && $past(pwdata[7]) == bank_select_bit)
      else $error("bank select moved without a write");
endmodule // fdf_props

bind fdf_top fdf_props #(.SEC_CYCLES(SEC_CYCLES)) i_fdf_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .serial_dtr_strap_pin(serial_dtr_strap_pin), .pon_duty_kept(pon_duty_kept),
   .fan1_duty(fan1_duty), .fan3_demand(fan3_demand), .fan3_duty(fan3_duty),
   .bank_select_bit(bank_select_bit)
);

// ===== fdf_fan_model.sv
`timescale 1ns/10ps
module fdf_fan_model (
   // clock
   input  wire        pclk,
   // drive from the block
   input  wire [7:0]  fan1_duty,
   input  wire [7:0]  fan3_duty,
   // scenario control
   input  wire [15:0] base_count,
   input  wire        stall3,
   // tachometer side
   output reg  [15:0] fan1_tach_count,
   output wire        fan1_stopped,
   output wire        fan3_stopped
);
   // a still rotor gives no pulses, so the count saturates
   always @(posedge pclk)
      fan1_tach_count <= (fan1_duty == 8'h00) ? 16'hFFFF : base_count;
   // combinational so a restart is not seen as a stall
   assign fan1_stopped = (fan1_duty == 8'h00);
   assign fan3_stopped = stall3 || (fan3_duty == 8'h00);
endmodule // fdf_fan_model

// ===== fdf_top_test.sv
`timescale 1ns/10ps
`include "fdf_map.vh"
module fdf_top_test;
   localparam SECS = 20;
   reg         pclk, presetn, psel, penable, pwrite, strap, kept, stall3, er;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, seed, rd, d;
   reg  [15:0] base;
   reg  [7:0]  temp, seg1, seg2, demand, s;
   reg  [7:0]  ixs [0:7];
   reg  [7:0]  msk [0:7];
   reg  [7:0]  rv [0:7];
   reg  [3:0]  mstart, hys;
   reg  [1:0]  mode;
   wire [31:0] prdata;
   wire [15:0] tach;
   wire [7:0]  f1d, f3d;
   wire        pready, pslverr, f1s, f3s, bank, irq;
   integer     n_errors, n_tests, i;
   integer     regm [0:255];

   fdf_top #(.SEC_CYCLES(SECS)) i_fdf_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_dtr_strap_pin(strap), .pon_duty_kept(kept), .fan1_tach_count(tach),
      .fan1_stopped(f1s), .fan1_min_start(mstart), .first_fan_mode_field(mode),
      .first_fan_hysteresis(hys), .temperature_source_one(temp), .fan1_segment1(seg1),
      .fan1_segment2(seg2), .fan1_duty(f1d), .fan3_demand(demand), .fan3_stopped(f3s),
      .fan3_duty(f3d), .bank_select_bit(bank), .irq(irq)
   );
   fdf_fan_model i_fdf_fan_model (
      .pclk(pclk), .fan1_duty(f1d), .fan3_duty(f3d), .base_count(base), .stall3(stall3),
      .fan1_tach_count(tach), .fan1_stopped(f1s), .fan3_stopped(f3s)
   );

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task chk(input [31:0] seen, input [31:0] want);
      begin
         n_tests = n_tests + 1;
         if (seen !== want)
         begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
         end
      end
   endtask

   task apb(input w, input [7:0] ix, input [31:0] wd);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {2'b00, ix, 2'b00};
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         // only the watchdog ends a wait for the answer
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task wr(input [7:0] ix, input [31:0] wd);
      apb(1'b1, ix, wd);
   endtask

   task rdc(input [7:0] ix, input [31:0] want);
      begin
         apb(1'b0, ix, 32'h0);
         chk(rd, want);
      end
   endtask

   task boot(input k, input st);
      begin
         @(posedge pclk);
         presetn <= 1'b0;
         kept <= k;
         strap <= st;
         repeat (12) @(posedge pclk);
         presetn <= 1'b1;
         // second edge lets the power-on checks finish before any new reset
         repeat (2) @(posedge pclk);
         @(negedge pclk);
      end
   endtask

   task fin(input integer k);
      $display("test %0d done", k);
   endtask

   task results;
      begin
         $display("tests %0d errors %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   initial
   begin
      #(50 * 5000);
      n_errors = n_errors + 1;
      results;
   end

   initial
   begin
      seed = 32'h3D7F9FC3;
      n_errors = 0;
      n_tests = 0;
      {presetn, psel, penable, pwrite, stall3, er} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      base = 16'h0000;
      {temp, seg1, seg2, demand} = 32'h0;
      mstart = 4'h5;
      hys = 4'h4;
      mode = 2'b10;
      ixs = '{8'h9D, 8'h9E, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'h9F};
      msk = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
      rv = '{8'h05, 8'h66, 8'h00, 8'h01, 8'h03, 8'hFF, 8'h3C, 8'h0A};
      boot(1'b0, 1'b1);
      chk(f1d, `FDF_DUTY_40);
      boot(1'b1, 1'b0);
      chk(f1d, `FDF_RST_PON_DUTY);
      boot(1'b0, 1'b0);
      chk(f1d, `FDF_DUTY_FULL);
      fin(1);
      for (i = 0; i < 8; i = i + 1)
      begin
         regm[ixs[i]] = rv[i];
         rdc(ixs[i], regm[ixs[i]]);
      end
      apb(1'b0, 8'h50, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      for (i = 0; i < 8; i = i + 1)
      begin
         d = $random(seed) & msk[i];
         regm[ixs[i]] = d;
         wr(ixs[i], d);
         if (ixs[i] == 8'hA5)
            rdc(8'hA4, regm[8'hA4]);
         rdc(ixs[i], regm[ixs[i]]);
      end
      fin(2);
      base <= 16'h1234;
      repeat (3) @(posedge pclk);
      rdc(8'hA0, 32'h12);
      base <= 16'h5678;
      repeat (3) @(posedge pclk);
      rdc(8'hA1, 32'h34);
      rdc(8'hA0, 32'h56);
      rdc(8'hA1, 32'h78);
      fin(3);
      wr(8'h9F, 32'h8A);
      rdc(8'h9D, 32'h0);
      chk(er, 1'b0);
      chk(bank, 1'b1);
      wr(8'h9D, 32'h0F);
      wr(8'h9F, 32'h0A);
      rdc(8'h9D, regm[8'h9D]);
      fin(4);
      d = $random(seed);
      wr(8'hA6, 32'h3C);
      mode <= 2'b00;
      seg1 <= d[7:0];
      seg2 <= d[15:8];
      temp <= 8'h50;
      rdc(8'hA3, d[7:0]);
      temp <= 8'h3A;
      rdc(8'hA3, d[7:0]);
      temp <= 8'hF0;
      rdc(8'hA3, d[15:8]);
      rdc(8'hA2, 32'h0);
      fin(5);
      mode <= 2'b11;
      // top bit kept low so the duty never reaches full before the timed fault
      wr(8'hA3, {25'h0, d[22:16]});
      rdc(8'hA2, 32'h0);
      chk(f1d, {25'h0, d[22:16]});
      wr(8'h9F, 32'h03);
      base <= 16'h1000;
      wr(8'hA3, 32'hFF);
      wr(8'hB0, 32'h03);
      repeat ((3 + 1) * SECS - 20) @(posedge pclk);
      rdc(8'hB0, 32'h0);
      repeat (20) @(posedge pclk);
      rdc(8'hB0, 32'h1);
      fin(6);
      base <= 16'h0000;
      s = 8'(2 + {$random(seed)} % 14);
      wr(8'h9D, {24'h0, s});
      wr(8'hB1, 32'h02);
      wr(8'hB0, 32'h03);
      demand <= s * 8'h06;
      i = 0;
      while (f3d === 8'h00 && i < 20)
      begin
         @(posedge pclk);
         i = i + 1;
      end
      chk(f3d, s * 8'h08);
      stall3 <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(irq, 1'b1);
      wr(8'hB1, 32'h0);
      rdc(8'hB0, 32'h2);
      chk(irq, 1'b0);
      stall3 <= 1'b0;
      wr(8'hB0, 32'h2);
      wr(8'hB1, 32'h2);
      rdc(8'hB0, 32'h0);
      chk(irq, 1'b0);
      demand <= s * 8'h04 - 8'h01;
      repeat (4) @(posedge pclk);
      chk(f3d, 32'h0);
      fin(7);
      results;
   end
endmodule // fdf_top_test
